/* File: core/psd_core.sv */
// Synthesizer core: bus latches, dividers, swallow logic, phase detector
`timescale 1ns/1ps
module psd_core
  import psd_pkg::*;
(
  input  wire logic             ref_clk_in,     // Reference oscillator clock
  input  wire logic             resetn_in,      // Sync reset, active low
  input  wire logic             ce_in,          // Clock enable
  input  wire logic [BUS_W-1:0] bus_data_in,    // Data nibble, bit 3 is msb
  input  wire logic [SEL_W-1:0] latch_sel_in,   // Latch select
  input  wire logic             latch_strobe_in,// Level strobe
  input  wire logic             fbk_in_in,      // Prescaled VCO input
  output logic                  tristate_phase_error_out, // Drive level
  output logic                  phase_error_oe_n_out,     // Low = driving
  output logic                  phi_fbk_n_out,  // Feedback-side pulse, low
  output logic                  phi_ref_n_out,  // Reference-side pulse, low
  output logic                  lock_indicator_out, // High when locked
  output logic                  mod_ctrl_out,   // Prescaler modulus control
  output logic                  ref_div_out,    // Divided reference pulse
  output logic                  fbk_div_out     // Divided feedback pulse
);
  logic [BUS_W-1:0] data_s;
  logic [SEL_W-1:0] sel_s;
  logic             strobe_s;
  logic             fin_s;
  logic             fin_d;
  logic             fin_rise;
  logic [BUS_W-1:0] prog_nib [NUM_LATCH];
  logic [REF_W-1:0] ref_val;
  logic [FBK_W-1:0] fbk_val;
  logic [SWL_W-1:0] swl_val;
  logic [REF_W-1:0] ref_cnt;
  logic [FBK_W-1:0] fbk_cnt;
  logic [SWL_W-1:0] swl_cnt;
  logic [SWL_W-1:0] next_swl;
  logic             ref_tick;
  logic             fbk_tick;
  logic             pd_up;
  logic             pd_dn;
  logic             next_up;
  logic             next_dn;

  // Bus, select, strobe and feedback pins pass two flops before any logic looks at them
  psd_sync #(.W(BUS_W + SEL_W + 2)) u_pin_sync (
    .clk_in    (ref_clk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .async_in  ({bus_data_in, latch_sel_in, latch_strobe_in, fbk_in_in}),
    .sync_out  ({data_s, sel_s, strobe_s, fin_s})
  );

  // Rising edge of the feedback input; one extra flop after the sync pair
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      fin_d <= 1'b0;
    else if (ce_in)
      fin_d <= fin_s;
  end
  assign fin_rise = fin_s & ~fin_d;

  // Transparent while strobe high; host must hold sel and data steady
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < NUM_LATCH; i++)
        prog_nib[i] <= LATCH_RST;
    end
    else if (ce_in && strobe_s)
      prog_nib[sel_s] <= data_s;
  end

  // Counter values assembled from latches in ascending nibble order
  assign swl_val = {prog_nib[SWL_LO_SEL + 3'h1][2:0],
                    prog_nib[SWL_LO_SEL]};
  assign fbk_val = {prog_nib[FBK_LO_SEL + 3'h2][1:0],
                    prog_nib[FBK_LO_SEL + 3'h1],
                    prog_nib[FBK_LO_SEL]};
  assign ref_val = {prog_nib[REF_LO_SEL + 3'h2],
                    prog_nib[REF_LO_SEL + 3'h1],
                    prog_nib[REF_LO_SEL]};

  // Reference divider: one tick every ref_val oscillator cycles
  assign ref_tick = ce_in && (ref_cnt <= CNT_END);
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      ref_cnt <= '0;
    else if (ce_in)
    begin
      if (ref_tick)
        ref_cnt <= ref_val;
      else
        ref_cnt <= ref_cnt - 12'h001;
    end
  end

  // Feedback counter ends a cycle after fbk_val input edges
  assign fbk_tick = ce_in && fin_rise && (fbk_cnt <= CNT_END[FBK_W-1:0]);
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      fbk_cnt <= '0;
    else if (ce_in && fin_rise)
    begin
      if (fbk_tick)
        fbk_cnt <= fbk_val;
      else
        fbk_cnt <= fbk_cnt - 10'h001;
    end
  end

  // Swallow counter counts down alongside, then stops at zero
  always_comb
  begin
    next_swl = swl_cnt;
    if (fbk_tick)
      next_swl = swl_val;
    else if (fin_rise && swl_cnt != 7'h00)
      next_swl = swl_cnt - 7'h01;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      swl_cnt <= '0;
    else if (ce_in)
      swl_cnt <= next_swl;
  end

  // Modulus low while swallowing, high for the rest of the cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      mod_ctrl_out <= 1'b1;
    else if (ce_in)
      mod_ctrl_out <= (next_swl == 7'h00);
  end

  // Divided outputs shown as one-cycle pulses
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      ref_div_out <= 1'b0;
      fbk_div_out <= 1'b0;
    end
    else if (ce_in)
    begin
      ref_div_out <= ref_tick;
      fbk_div_out <= fbk_tick;
    end
  end

  // Phase-frequency detector; coincident edges cancel at once
  always_comb
  begin
    next_up = pd_up | ref_tick;
    next_dn = pd_dn | fbk_tick;
    if (next_up && next_dn)
    begin
      next_up = 1'b0;
      next_dn = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      pd_up <= 1'b0;
      pd_dn <= 1'b0;
    end
    else if (ce_in)
    begin
      pd_up <= next_up;
      pd_dn <= next_dn;
    end
  end

  // Error outputs; up means feedback lags, dn means it leads
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      tristate_phase_error_out <= 1'b0;
      phase_error_oe_n_out     <= 1'b1;
      phi_fbk_n_out            <= 1'b1;
      phi_ref_n_out            <= 1'b1;
      lock_indicator_out       <= 1'b1;
    end
    else if (ce_in)
    begin
      tristate_phase_error_out <= pd_up;
      phase_error_oe_n_out     <= ~(pd_up | pd_dn);
      phi_fbk_n_out            <= ~pd_dn;
      phi_ref_n_out            <= ~pd_up;
      lock_indicator_out       <= ~(pd_up | pd_dn);
    end
  end

  // Checks on the logic above
  property p_latch_load;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    strobe_s |=> prog_nib[$past(sel_s)] == $past(data_s);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("addressed latch did not take bus nibble");

  property p_latch_hold;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    !strobe_s |=> $stable(ref_val) && $stable(fbk_val) && $stable(swl_val);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed while strobe low");

  property p_ref_reload;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    ref_tick |=> ref_cnt == $past(ref_val) && ref_div_out;
  endproperty
  a_ref_reload: assert property (p_ref_reload)
    else $error("reference divider did not reload");

  property p_fbk_reload;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    fbk_tick |=> fbk_cnt == $past(fbk_val) && swl_cnt == $past(swl_val);
  endproperty
  a_fbk_reload: assert property (p_fbk_reload)
    else $error("feedback or swallow counter did not reload");

  property p_mod_ctrl;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    (fbk_tick && swl_val != 7'h00) |=> !mod_ctrl_out;
  endproperty
  a_mod_ctrl: assert property (p_mod_ctrl)
    else $error("modulus control not low at start of count cycle");

  property p_pd_neg;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    pd_dn |=> !phase_error_oe_n_out && !tristate_phase_error_out;
  endproperty
  a_pd_neg: assert property (p_pd_neg)
    else $error("leading feedback did not drive low");

  property p_pd_pos;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    pd_up |=> !phase_error_oe_n_out && tristate_phase_error_out;
  endproperty
  a_pd_pos: assert property (p_pd_pos)
    else $error("lagging feedback did not drive high");

  property p_pd_hiz;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    (ref_tick && fbk_tick && !pd_up && !pd_dn) |=> ##1 phase_error_oe_n_out;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz)
    else $error("coincident edges drove the error output");

  property p_dual;
    @(posedge ref_clk_in) disable iff (!resetn_in || !ce_in)
    pd_dn |=> !phi_fbk_n_out && phi_ref_n_out && !lock_indicator_out;
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual outputs or lock wrong for leading feedback");
endmodule // psd_core

/* File: core/psd_pkg.sv */
// Package: widths, latch map and reset values of the synthesizer core
package psd_pkg;
  localparam int unsigned BUS_W      = 4;   // Data bus nibble width
  localparam int unsigned SEL_W      = 3;   // Latch select width
  localparam int unsigned NUM_LATCH  = 8;   // Program latches
  localparam int unsigned REF_W      = 12;  // Reference divider width
  localparam int unsigned FBK_W      = 10;  // Feedback counter width
  localparam int unsigned SWL_W      = 7;   // Swallow counter width
  // Latch codes holding the low nibble of each counter
  localparam logic [2:0]  SWL_LO_SEL = 3'h0;
  localparam logic [2:0]  FBK_LO_SEL = 3'h2;
  localparam logic [2:0]  REF_LO_SEL = 3'h5;
  // Reset value of every program latch
  localparam logic [3:0]  LATCH_RST  = 4'h0;
  // Reload threshold: a count at or below this value ends a cycle
  localparam logic [11:0] CNT_END    = 12'h001;
endpackage

/* File: core/psd_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module psd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,    // Core clock
  input  wire logic         resetn_in, // Sync reset, active low
  input  wire logic         ce_in,     // Clock enable
  input  wire logic [W-1:0] async_in,  // Pin level
  output logic      [W-1:0] sync_out   // Synchronised level
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else if (ce_in)
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // psd_sync

/* File: sim/psd_host.sv */
// Host controller and prescaler model driving the core's input pins
`timescale 1ns/1ps
module psd_host (
  input  wire logic       clk_in,     // Core clock
  output logic      [3:0] data_out,   // Data nibble, bit 3 msb
  output logic      [2:0] sel_out,    // Latch select
  output logic            strobe_out, // Level strobe
  output logic            fbk_out     // Prescaled VCO square wave
);
  int half_clk = 0; // Feedback half period in clocks, 0 stands still

  initial
  begin
    data_out = 4'h0;
    sel_out = 3'h0;
    strobe_out = 1'b0;
    fbk_out = 1'b0;
  end

  // Pins stay put three clocks around the strobe, beyond the sync delay
  task automatic put(input logic [2:0] s, input logic [3:0] d);
    sel_out = s;
    data_out = d;
    repeat (3) @(negedge clk_in);
    strobe_out = 1'b1;
    repeat (3) @(negedge clk_in);
    strobe_out = 1'b0;
    repeat (3) @(negedge clk_in);
    data_out = ~d; // Stale bus, so a late write would show
    @(negedge clk_in); // Next call must not overwrite it in this step
  endtask

  // Feedback edges every half_clk clocks; half_clk must be 3 or more
  always
  begin
    @(negedge clk_in);
    if (half_clk > 0)
    begin
      repeat (half_clk - 1) @(negedge clk_in);
      fbk_out = ~fbk_out;
    end
  end
endmodule // psd_host

/* File: sim/pll_synth_divider_core_bench.sv */
// Self-checking bench for the synthesizer core
`timescale 1ns/1ps
module pll_synth_divider_core_bench;
  import psd_pkg::*;
  logic             ref_clk_in = 1'b0;
  logic             resetn_in = 1'b0;
  logic             ce_in = 1'b1;
  logic [BUS_W-1:0] bus_data;
  logic [SEL_W-1:0] sel;
  logic             strobe, fbk, err, oe_n, phi_v_n, phi_r_n;
  logic             lock, mod_ctrl, ref_div, fbk_div;
  int               failures = 0;
  int               tests_run = 0;
  int               cyc = 0;
  int               r_last = 0, f_last = 0, m_low = 0, pd_seen = 0;
  int               rq[$], fq[$], mq[$];
  logic             pq[$];
  int               rt[3] = '{3, 10, 4095};
  int               nt[3] = '{3, 1023, 0};
  int               at[3] = '{1, 127, 0};

  always #20 ref_clk_in = ~ref_clk_in;

  psd_host host (.clk_in(ref_clk_in), .data_out(bus_data), .sel_out(sel),
    .strobe_out(strobe), .fbk_out(fbk));

  psd_core uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .ce_in(ce_in), .bus_data_in(bus_data), .latch_sel_in(sel),
    .latch_strobe_in(strobe), .fbk_in_in(fbk),
    .tristate_phase_error_out(err), .phase_error_oe_n_out(oe_n),
    .phi_fbk_n_out(phi_v_n), .phi_ref_n_out(phi_r_n),
    .lock_indicator_out(lock), .mod_ctrl_out(mod_ctrl),
    .ref_div_out(ref_div), .fbk_div_out(fbk_div));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Mismatches %0d, checks %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Loads all eight latches, ascending nibbles, then lets counters reload
  task automatic load_all(input logic [11:0] r, input logic [9:0] n,
                          input logic [6:0] a);
    host.put(3'h0, a[3:0]);
    host.put(3'h1, {1'b0, a[6:4]});
    host.put(3'h2, n[3:0]);
    host.put(3'h3, n[7:4]);
    host.put(3'h4, {2'b00, n[9:8]});
    host.put(3'h5, r[3:0]);
    host.put(3'h6, r[7:4]);
    host.put(3'h7, r[11:8]);
    repeat (300) @(negedge ref_clk_in);
  endtask

  // Watcher: outputs are settled at the falling edge
  always @(negedge ref_clk_in)
  begin
    cyc++;
    if (cyc > 60000)
    begin
      failures++;
      give_verdict();
    end
    if (ref_div === 1'b1)
    begin
      if (rq.size() > 0) check("ref period", cyc - r_last, rq.pop_front());
      r_last = cyc;
    end
    if (fbk_div === 1'b1)
    begin
      if (fq.size() > 0) check("fbk period", cyc - f_last, fq.pop_front());
      f_last = cyc;
    end
    if (mod_ctrl === 1'b0)
      m_low++;
    else
    begin
      if (m_low > 0 && mq.size() > 0) check("mod low", m_low, mq.pop_front());
      m_low = 0;
    end
    if (oe_n === 1'b0 && pq.size() > 0)
    begin
      pd_seen++;
      check("pd level", err, pq[0]);
      check("phi fbk", phi_v_n, pq[0]);
      check("phi ref", phi_r_n, !pq[0]);
      check("lock", lock, 1'b0);
    end
  end

  initial
  begin
    void'($urandom(80778));
    nt[2] = $urandom_range(9, 4);
    at[2] = $urandom_range(3, 1);
    repeat (12) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    check("idle oe_n", oe_n, 1'b1);
    host.half_clk = 4;
    // Reference 40 clocks against feedback 32 (fast) then 48 (slow)
    for (int k = 0; k < 2; k++)
    begin
      load_all(12'h028, (k == 0) ? 10'h004 : 10'h006, 7'h01);
      pd_seen = 0;
      pq.push_back(k[0]);
      repeat (400) @(negedge ref_clk_in);
      pq.delete();
      check("pd pulses", pd_seen > 0, 1'b1);
    end
    // Divider boundaries; one feedback edge is eight clocks
    foreach (rt[i])
    begin
      load_all(rt[i][11:0], nt[i][9:0], at[i][6:0]);
      // A cycle begun with half-written latches ends at the next pulse
      @(posedge ref_div);
      repeat (2) @(negedge ref_clk_in);
      rq.push_back(rt[i]);
      @(posedge fbk_div);
      repeat (2) @(negedge ref_clk_in);
      fq.push_back(nt[i] * 8);
      // Two edges on, so the watcher has closed the earlier low stretch
      @(posedge mod_ctrl);
      repeat (2) @(negedge ref_clk_in);
      mq.push_back(at[i] * 8);
      wait (rq.size() + fq.size() + mq.size() == 0);
    end
    give_verdict();
  end
endmodule // pll_synth_divider_core_bench
